//--- shared/ext_reg_pkg.sv
// shared modes, configuration states and reset values of the third-supply control
package ext_reg_pkg;

  typedef enum logic [5:0] {
    MODE_INIT     = 6'h01,
    MODE_NORMAL   = 6'h02,
    MODE_STOP     = 6'h04,
    MODE_SLEEP    = 6'h08,
    MODE_RESTART  = 6'h10,
    MODE_FAILSAFE = 6'h20
  } dev_mode_t;

  typedef enum logic [2:0] {
    CFG_NONE       = 3'h1,
    CFG_STANDALONE = 3'h2,
    CFG_LOADSHARE  = 3'h4
  } cfg_state_t;

  localparam logic FLAG_RESET  = 1'b0;
  localparam logic CTRL_RESET  = 1'b0;
  localparam logic VSEL_RESET  = 1'b0;
  localparam logic VSEL_LSHARE = 1'b0;

endpackage

//--- shared/ext_reg_cfg_if.sv
// configuration lock state shared between the regulator control modules
`timescale 1ns/1ns
interface ext_reg_cfg_if;
  logic standalone;
  logic loadShare;
  logic regOn;
  logic regEnable;

  modport lockSide (output standalone, output loadShare, output regOn);
  modport flagSide (input standalone, input regEnable);
  modport topSide  (input standalone, input loadShare, input regOn, output regEnable);
endinterface

//--- design/ext_reg_cfg_lock.sv
// one-time configuration lock and regulator-on control bit
`timescale 1ns/1ns
module ext_reg_cfg_lock (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         softReset,
  input  wire logic         ctrlWrite,
  input  wire logic         onData,
  input  wire logic         lsData,
  output logic              commandFail,
  ext_reg_cfg_if.lockSide   cfg
);

  ext_reg_pkg::cfg_state_t state_reg;
  ext_reg_pkg::cfg_state_t state_next;
  logic                    regOn_reg;
  logic                    fail_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ext_reg_pkg::CFG_NONE: begin
        if (ctrlWrite && lsData) begin
          state_next = ext_reg_pkg::CFG_LOADSHARE;
        end else if (ctrlWrite && onData) begin
          state_next = ext_reg_pkg::CFG_STANDALONE;
        end
      end
      ext_reg_pkg::CFG_STANDALONE: state_next = ext_reg_pkg::CFG_STANDALONE;
      ext_reg_pkg::CFG_LOADSHARE:  state_next = ext_reg_pkg::CFG_LOADSHARE;
      default:                     state_next = ext_reg_pkg::CFG_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ext_reg_pkg::CFG_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      regOn_reg <= ext_reg_pkg::CTRL_RESET;
    end else if (ctrlWrite && state_next == ext_reg_pkg::CFG_STANDALONE) begin
      regOn_reg <= onData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      fail_reg <= ext_reg_pkg::FLAG_RESET;
    end else begin
      fail_reg <= ctrlWrite && state_reg == ext_reg_pkg::CFG_LOADSHARE && (!lsData || onData);
    end
  end

  assign cfg.standalone = state_reg == ext_reg_pkg::CFG_STANDALONE;
  assign cfg.loadShare  = state_reg == ext_reg_pkg::CFG_LOADSHARE;
  assign cfg.regOn      = regOn_reg;
  assign commandFail    = fail_reg;

endmodule

//--- design/ext_reg_status_flags.sv
// sticky overcurrent and undervoltage flags of the third supply
`timescale 1ns/1ns
module ext_reg_status_flags (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         shuntLimit,
  input  wire logic         thirdUv,
  input  wire logic         ocClear,
  input  wire logic         uvClear,
  output logic              ocFlag,
  output logic              uvFlag,
  ext_reg_cfg_if.flagSide   cfg
);

  logic ocFlag_reg;
  logic uvFlag_reg;
  logic ocSet;
  logic uvSet;

  assign ocSet = cfg.standalone && cfg.regEnable && shuntLimit;
  assign uvSet = cfg.standalone && cfg.regEnable && thirdUv;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ocFlag_reg <= ext_reg_pkg::FLAG_RESET;
    end else if (ocSet) begin
      ocFlag_reg <= 1'b1;
    end else if (ocClear && !shuntLimit) begin
      ocFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      uvFlag_reg <= ext_reg_pkg::FLAG_RESET;
    end else if (uvSet) begin
      uvFlag_reg <= 1'b1;
    end else if (uvClear) begin
      uvFlag_reg <= 1'b0;
    end
  end

  assign ocFlag = ocFlag_reg;
  assign uvFlag = uvFlag_reg;

endmodule

//--- design/ext_regulator_config_lock.sv
// third-supply regulator control: configuration lock, per-mode enable, status
`timescale 1ns/1ns
// How it works
// - stand-alone locks; on/off still allowed
// - stand-alone config change ignored, no fail
// - stand-alone limit sets overcurrent; clear after
// - stand-alone undervoltage monitored and flagged
// - first load-share set locks; on ignored
// - load-share change refused, fail flag set
// - load share in normal and restart, stop if kept
// - stop without keep switches load share off
// - load-share bit stays; resumes in normal
// - load share never flags undervoltage
// - fail-safe mode switches regulator off
// - load share: no limiting, no overcurrent
// - supply undervoltage off; optional keep-off
// - voltage select ignored in load share
// - lock survives soft reset
module ext_regulator_config_lock (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   softReset,
  input  wire ext_reg_pkg::dev_mode_t deviceMode,
  input  wire logic                   ctrlWrite,
  input  wire logic                   standaloneRegulatorOn,
  input  wire logic                   loadShareSelect,
  input  wire logic                   loadShareKeepInStop,
  input  wire logic                   keepOffAfterSupplyUndervoltage,
  input  wire logic                   thirdSupplyVoltageSelect,
  input  wire logic                   supplyUndervoltage,
  input  wire logic                   shuntThresholdReached,
  input  wire logic                   thirdSupplyLow,
  input  wire logic                   overcurrentClear,
  input  wire logic                   undervoltageClear,
  output logic                        regulatorEnable,
  output logic                        loadShareActive,
  output logic                        currentLimitEnable,
  output logic                        undervoltageMonitorEnable,
  output logic                        voltageSelectOut,
  output logic                        thirdSupplyOvercurrentFlag,
  output logic                        thirdSupplyUndervoltageFlag,
  output logic                        commandFail,
  output logic                        configStandalone,
  output logic                        configLoadShare,
  output logic                        regulatorOnReadback
);

  ext_reg_cfg_if cfgBus ();

  logic regEnable_reg;
  logic regEnable_next;
  logic lsActive_reg;
  logic limitEn_reg;
  logic uvMon_reg;
  logic vsel_reg;
  logic uvHold_reg;
  logic saModeOk;
  logic lsModeOk;
  logic supplyBlock;
  logic saOn;
  logic lsOn;

  ext_reg_cfg_lock lockUnit (
    .clk         (clk),
    .nrst        (nrst),
    .softReset   (softReset),
    .ctrlWrite   (ctrlWrite),
    .onData      (standaloneRegulatorOn),
    .lsData      (loadShareSelect),
    .commandFail (commandFail),
    .cfg         (cfgBus.lockSide)
  );

  ext_reg_status_flags flagUnit (
    .clk        (clk),
    .nrst       (nrst),
    .shuntLimit (shuntThresholdReached),
    .thirdUv    (thirdSupplyLow),
    .ocClear    (overcurrentClear),
    .uvClear    (undervoltageClear),
    .ocFlag     (thirdSupplyOvercurrentFlag),
    .uvFlag     (thirdSupplyUndervoltageFlag),
    .cfg        (cfgBus.flagSide)
  );

  assign cfgBus.regEnable = regEnable_reg;

  always_comb begin
    saModeOk = 1'b0;
    lsModeOk = 1'b0;
    case (deviceMode)
      ext_reg_pkg::MODE_NORMAL: begin
        saModeOk = 1'b1;
        lsModeOk = 1'b1;
      end
      ext_reg_pkg::MODE_STOP: begin
        saModeOk = 1'b1;
        lsModeOk = loadShareKeepInStop;
      end
      ext_reg_pkg::MODE_SLEEP: begin
        saModeOk = 1'b1;
      end
      ext_reg_pkg::MODE_RESTART: begin
        saModeOk = 1'b1;
        lsModeOk = 1'b1;
      end
      default: begin
        saModeOk = 1'b0;
        lsModeOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      uvHold_reg <= ext_reg_pkg::CTRL_RESET;
    end else if (supplyUndervoltage && keepOffAfterSupplyUndervoltage) begin
      uvHold_reg <= 1'b1;
    end else if (ctrlWrite) begin
      uvHold_reg <= 1'b0;
    end
  end

  assign supplyBlock = supplyUndervoltage || uvHold_reg;
  assign saOn = cfgBus.standalone && cfgBus.regOn && saModeOk && !supplyBlock;
  assign lsOn = cfgBus.loadShare && lsModeOk && !supplyBlock;
  assign regEnable_next = saOn || lsOn;

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      regEnable_reg <= ext_reg_pkg::CTRL_RESET;
    end else begin
      regEnable_reg <= regEnable_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      lsActive_reg <= ext_reg_pkg::CTRL_RESET;
    end else begin
      lsActive_reg <= lsOn;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      limitEn_reg <= ext_reg_pkg::CTRL_RESET;
      uvMon_reg   <= ext_reg_pkg::CTRL_RESET;
    end else begin
      limitEn_reg <= saOn;
      uvMon_reg   <= saOn;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vsel_reg <= ext_reg_pkg::VSEL_RESET;
    end else if (cfgBus.standalone) begin
      vsel_reg <= thirdSupplyVoltageSelect;
    end else begin
      vsel_reg <= ext_reg_pkg::VSEL_LSHARE;
    end
  end

  assign regulatorEnable           = regEnable_reg;
  assign loadShareActive           = lsActive_reg;
  assign currentLimitEnable        = limitEn_reg;
  assign undervoltageMonitorEnable = uvMon_reg;
  assign voltageSelectOut          = vsel_reg;
  assign configStandalone          = cfgBus.standalone;
  assign configLoadShare           = cfgBus.loadShare;
  assign regulatorOnReadback       = cfgBus.regOn;

  // checks

  sa_lock_kept_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.standalone && ctrlWrite && !softReset |=> cfgBus.standalone && !cfgBus.loadShare &&
      cfgBus.regOn == $past(standaloneRegulatorOn)
  ) else $error("stand-alone lock or on bit wrong after write");

  sa_no_fail_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.standalone && ctrlWrite && !softReset |=> !commandFail
  ) else $error("fail flagged in stand-alone");

  oc_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    thirdSupplyOvercurrentFlag && shuntThresholdReached |=> thirdSupplyOvercurrentFlag
  ) else $error("overcurrent cleared while present");

  oc_set_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.standalone && regEnable_reg && shuntThresholdReached |=> thirdSupplyOvercurrentFlag
  ) else $error("overcurrent not flagged");

  uv_flag_set_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.standalone && regEnable_reg && thirdSupplyLow |=> thirdSupplyUndervoltageFlag
  ) else $error("undervoltage not flagged");

  ls_on_ignored_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare |-> !cfgBus.standalone && !cfgBus.regOn
  ) else $error("on bit active in load share");

  ls_fail_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare && ctrlWrite && !softReset && (!loadShareSelect || standaloneRegulatorOn)
      |=> commandFail && cfgBus.loadShare
  ) else $error("refused change not flagged");

  ls_normal_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare && deviceMode == ext_reg_pkg::MODE_NORMAL && !supplyBlock && !softReset
      |=> loadShareActive && regulatorEnable
  ) else $error("load share not active in normal");

  ls_stop_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    deviceMode == ext_reg_pkg::MODE_STOP && !loadShareKeepInStop && cfgBus.loadShare
      |=> !loadShareActive && !regulatorEnable
  ) else $error("load share kept in stop");

  ls_resume_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare && deviceMode == ext_reg_pkg::MODE_STOP ##1
      deviceMode == ext_reg_pkg::MODE_NORMAL && !supplyBlock && !softReset
      |=> cfgBus.loadShare && loadShareActive
  ) else $error("load share did not resume");

  ls_no_uv_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare |-> !thirdSupplyUndervoltageFlag && !undervoltageMonitorEnable
  ) else $error("undervoltage in load share");

  failsafe_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    deviceMode == ext_reg_pkg::MODE_FAILSAFE |=> !regulatorEnable
  ) else $error("regulator on in fail-safe");

  ls_no_oc_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare |-> !thirdSupplyOvercurrentFlag && !currentLimitEnable
  ) else $error("current limit in load share");

  vs_uv_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    supplyUndervoltage && keepOffAfterSupplyUndervoltage ##1 !supplyUndervoltage && !ctrlWrite
      |=> !regulatorEnable
  ) else $error("regulator back on despite keep-off");

  vsel_ls_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cfgBus.loadShare |=> voltageSelectOut == ext_reg_pkg::VSEL_LSHARE
  ) else $error("voltage select used in load share");

  soft_keep_a: assert property (
    @(posedge clk) disable iff (!nrst)
    softReset && !ctrlWrite |=> cfgBus.loadShare == $past(cfgBus.loadShare) &&
      cfgBus.standalone == $past(cfgBus.standalone)
  ) else $error("soft reset lost configuration");

  both_first_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !cfgBus.loadShare && !cfgBus.standalone && ctrlWrite && loadShareSelect && standaloneRegulatorOn
      |=> cfgBus.loadShare
  ) else $error("load share lost priority");

endmodule

//--- bench/tb.sv
// self-checking bench of the third-supply regulator control
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    ext_reg_pkg::dev_mode_t mode;
    logic                   keep;
    logic                   expOn;
  } row_t;

  logic                   clk          = 1'b0;
  logic                   nrst         = 1'b0;
  logic                   softReset    = 1'b0;
  ext_reg_pkg::dev_mode_t deviceMode   = ext_reg_pkg::MODE_INIT;
  logic                   ctrlWrite    = 1'b0;
  logic                   onBit        = 1'b0;
  logic                   lsBit        = 1'b0;
  logic                   keepStop     = 1'b0;
  logic                   keepOff      = 1'b0;
  logic                   vsel         = 1'b0;
  logic                   supplyUv     = 1'b0;
  logic                   shunt        = 1'b0;
  logic                   thirdLow     = 1'b0;
  logic                   ocClr        = 1'b0;
  logic                   uvClr        = 1'b0;
  logic                   regEn;
  logic                   lsActive;
  logic                   limitEn;
  logic                   uvMonEn;
  logic                   vselOut;
  logic                   ocFlag;
  logic                   uvFlag;
  logic                   cmdFail;
  logic                   cfgSa;
  logic                   cfgLs;
  logic                   onRb;
  int                     failCount    = 0;
  int                     totalChecks  = 0;
  row_t                   rows [8]     = '{
    '{ext_reg_pkg::MODE_NORMAL, 1'b0, 1'b1}, '{ext_reg_pkg::MODE_STOP, 1'b0, 1'b0},
    '{ext_reg_pkg::MODE_NORMAL, 1'b0, 1'b1}, '{ext_reg_pkg::MODE_STOP, 1'b1, 1'b1},
    '{ext_reg_pkg::MODE_SLEEP, 1'b1, 1'b0}, '{ext_reg_pkg::MODE_RESTART, 1'b0, 1'b1},
    '{ext_reg_pkg::MODE_FAILSAFE, 1'b0, 1'b0}, '{ext_reg_pkg::MODE_INIT, 1'b0, 1'b0}};

  ext_regulator_config_lock DUT (
    .clk(clk), .nrst(nrst), .softReset(softReset), .deviceMode(deviceMode), .ctrlWrite(ctrlWrite),
    .standaloneRegulatorOn(onBit), .loadShareSelect(lsBit), .loadShareKeepInStop(keepStop),
    .keepOffAfterSupplyUndervoltage(keepOff), .thirdSupplyVoltageSelect(vsel),
    .supplyUndervoltage(supplyUv), .shuntThresholdReached(shunt), .thirdSupplyLow(thirdLow),
    .overcurrentClear(ocClr), .undervoltageClear(uvClr), .regulatorEnable(regEn),
    .loadShareActive(lsActive), .currentLimitEnable(limitEn), .undervoltageMonitorEnable(uvMonEn),
    .voltageSelectOut(vselOut), .thirdSupplyOvercurrentFlag(ocFlag),
    .thirdSupplyUndervoltageFlag(uvFlag), .commandFail(cmdFail), .configStandalone(cfgSa),
    .configLoadShare(cfgLs), .regulatorOnReadback(onRb));

  always #10 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      $display("Error at %0t ns: %s", $time, msg);
      failCount++;
    end
  endtask

  // one-cycle control write, returns when the lock result is visible
  task automatic wr(input logic on, input logic ls);
    @(negedge clk);
    ctrlWrite = 1'b1;
    onBit = on;
    lsBit = ls;
    @(negedge clk);
    ctrlWrite = 1'b0;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    onBit = 1'b0; // unused regulator left off
    step(6);
    nrst = 1'b1;
    chk(cfgSa | cfgLs | onRb, 1'b0, "lock not clear after reset");
    chk(regEn | lsActive | ocFlag | uvFlag | cmdFail, 1'b0, "outputs not clear after reset");
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    end_sim();
  end

  initial begin
    do_reset();
    deviceMode = ext_reg_pkg::MODE_NORMAL;
    vsel = 1'b0; // share voltage matches main
    wr(1'b1, 1'b1);
    chk(cfgLs, 1'b1, "both bits did not lock load share");
    chk(cfgSa, 1'b0, "both bits locked stand-alone");
    for (int i = 0; i < 8; i++) begin
      deviceMode = rows[i].mode;
      keepStop = rows[i].keep;
      step(2);
      chk(regEn, rows[i].expOn, "load share enable by mode");
      chk(lsActive, rows[i].expOn, "load share activity by mode");
      chk(cfgLs, 1'b1, "load share bit lost");
    end
    deviceMode = ext_reg_pkg::MODE_NORMAL;
    wr(1'b0, 1'b0);
    chk(cmdFail, 1'b1, "refused write gave no fail");
    step(1);
    chk(cmdFail, 1'b0, "fail longer than one cycle");
    chk(cfgLs, 1'b1, "load share lock changed");
    wr(1'b1, 1'b1);
    chk(cmdFail, 1'b1, "on bit in load share not refused");
    chk(cfgSa, 1'b0, "config changed to stand-alone");
    chk(onRb, 1'b0, "on bit stored in load share");
    wr(1'b0, 1'b1);
    chk(cmdFail, 1'b0, "plain load share write refused");
    shunt = 1'b1;
    thirdLow = 1'b1;
    vsel = 1'b1;
    step(3);
    chk(ocFlag | limitEn, 1'b0, "overcurrent in load share");
    chk(uvFlag | uvMonEn, 1'b0, "undervoltage in load share");
    chk(vselOut, 1'b0, "voltage select used in load share");
    chk(regEn, 1'b1, "limit disabled load share");
    shunt = 1'b0;
    thirdLow = 1'b0;
    vsel = 1'b0;
    softReset = 1'b1;
    step(1);
    softReset = 1'b0;
    step(2);
    chk(cfgLs, 1'b1, "soft reset lost load share lock");

    do_reset();
    wr(1'b0, 1'b0);
    chk(cfgSa | cfgLs | cmdFail, 1'b0, "empty write locked a configuration");
    wr(1'b1, 1'b0);
    chk(cfgSa, 1'b1, "stand-alone not locked");
    chk(onRb, 1'b1, "on bit not stored");
    step(1);
    chk(regEn & limitEn & uvMonEn, 1'b1, "stand-alone not running");
    wr(1'b1, 1'b1);
    chk(cmdFail, 1'b0, "stand-alone change set fail");
    chk(cfgLs, 1'b0, "stand-alone changed to load share");
    wr(1'b0, 1'b0);
    step(1);
    chk(regEn, 1'b0, "stand-alone not switched off");
    wr(1'b1, 1'b0);
    vsel = 1'b1;
    step(2);
    chk(regEn, 1'b1, "stand-alone not switched on again");
    chk(vselOut, 1'b1, "voltage select not passed");
    shunt = 1'b1;
    step(2);
    chk(ocFlag, 1'b1, "overcurrent not flagged");
    chk(regEn, 1'b1, "overcurrent switched regulator off");
    ocClr = 1'b1;
    step(1);
    ocClr = 1'b0;
    step(1);
    chk(ocFlag, 1'b1, "flag cleared during overcurrent");
    shunt = 1'b0;
    step(1);
    ocClr = 1'b1;
    step(1);
    ocClr = 1'b0;
    step(1);
    chk(ocFlag, 1'b0, "overcurrent flag not cleared");
    thirdLow = 1'b1;
    step(2);
    chk(uvFlag, 1'b1, "undervoltage not flagged");
    thirdLow = 1'b0;
    uvClr = 1'b1;
    step(1);
    uvClr = 1'b0;
    step(1);
    chk(uvFlag, 1'b0, "undervoltage flag not cleared");
    deviceMode = ext_reg_pkg::MODE_FAILSAFE;
    step(2);
    chk(regEn, 1'b0, "fail-safe left regulator on");
    deviceMode = ext_reg_pkg::MODE_SLEEP;
    step(2);
    chk(regEn, 1'b1, "stand-alone off in sleep");
    deviceMode = ext_reg_pkg::MODE_STOP;
    step(2);
    chk(regEn, 1'b1, "stand-alone off in stop");
    deviceMode = ext_reg_pkg::MODE_INIT;
    step(2);
    chk(regEn, 1'b0, "stand-alone on in init");
    deviceMode = ext_reg_pkg::MODE_NORMAL;
    supplyUv = 1'b1;
    step(2);
    chk(regEn, 1'b0, "supply drop left regulator on");
    supplyUv = 1'b0;
    step(2);
    chk(regEn, 1'b1, "no recovery after supply drop");
    keepOff = 1'b1;
    supplyUv = 1'b1;
    step(2);
    supplyUv = 1'b0;
    step(2);
    chk(regEn, 1'b0, "keep-off ignored");
    wr(1'b1, 1'b0);
    step(1);
    chk(regEn, 1'b1, "write did not re-enable");
    softReset = 1'b1;
    step(1);
    softReset = 1'b0;
    step(2);
    chk(cfgSa, 1'b1, "soft reset lost stand-alone lock");
    chk(onRb | regEn, 1'b0, "soft reset kept regulator on");
    end_sim();
  end
endmodule
